//--- include/spp_pkg.sv
package spp_pkg;

    // Port width and register indices as printed; byte address is four times the index
    localparam int unsigned SPP_WIDTH = 8;
    localparam logic [31:0] SPP_IDX_DATA = 32'hFFFFF051;
    localparam logic [31:0] SPP_IDX_DIR = 32'hFFFFF055;
    localparam logic [31:0] SPP_IDX_FUNC = 32'hFFFFF059;
    localparam logic [31:0] SPP_IDX_OD = 32'hFFFFF05D;
    localparam logic [31:0] SPP_ADDR_DATA = SPP_IDX_DATA << 2;
    localparam logic [31:0] SPP_ADDR_DIR = SPP_IDX_DIR << 2;
    localparam logic [31:0] SPP_ADDR_FUNC = SPP_IDX_FUNC << 2;
    localparam logic [31:0] SPP_ADDR_OD = SPP_IDX_OD << 2;

    // Reset values
    localparam logic [7:0] SPP_RST_DATA = 8'hFF;
    localparam logic [7:0] SPP_RST_DIR = 8'h00;
    localparam logic [7:0] SPP_RST_FUNC = 8'h00;
    localparam logic [7:0] SPP_RST_OD = 8'h00;

    // Bit roles under function select
    localparam logic [7:0] SPP_TX_BITS = 8'h49;
    localparam logic [7:0] SPP_RX_BITS = 8'h92;
    localparam logic [7:0] SPP_CLK_BITS = 8'h24;
    localparam logic [7:0] SPP_OD_MASK = 8'h6D;
    localparam int unsigned SPP_CH_STRIDE = 3;

    // Bus answers
    localparam logic [1:0] SPP_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPP_RESP_SLVERR = 2'h2;

    typedef enum {SPP_SEL_NONE, SPP_SEL_DATA, SPP_SEL_DIR, SPP_SEL_FUNC, SPP_SEL_OD} spp_sel_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } spp_wr_t;

    // Address to register select
    function automatic spp_sel_t spp_decode(input logic [31:0] addr);
        spp_sel_t sel;
        sel = SPP_SEL_NONE;
        if (addr == SPP_ADDR_DATA) begin
            sel = SPP_SEL_DATA;
        end else if (addr == SPP_ADDR_DIR) begin
            sel = SPP_SEL_DIR;
        end else if (addr == SPP_ADDR_FUNC) begin
            sel = SPP_SEL_FUNC;
        end else if (addr == SPP_ADDR_OD) begin
            sel = SPP_SEL_OD;
        end
        return sel;
    endfunction

endpackage

//--- logic/spp_axil.sv
`timescale 1ns/100ps
`default_nettype none
module spp_axil
    import spp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [31:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [31:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic wr_en_out,
    output spp_wr_t wr_out,
    input wire logic wr_hit_in,
    output logic rd_en_out,
    output logic [31:0] rd_addr_out,
    input wire logic [31:0] rd_data_in,
    input wire logic rd_hit_in
);
    logic aw_have_ff;
    logic w_have_ff;
    logic rd_pend_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [31:0] araddr_ff;

    // Ready while the holding slot is free and no answer waits
    assign awready_out = !aw_have_ff && !bvalid_out;
    assign wready_out = !w_have_ff && !bvalid_out;
    assign arready_out = !rd_pend_ff && !rvalid_out;
    assign wr_en_out = aw_have_ff && w_have_ff;
    assign wr_out = '{addr: awaddr_ff, data: wdata_ff, strb: wstrb_ff};
    assign rd_en_out = rd_pend_ff;
    assign rd_addr_out = araddr_ff;

    // Write address slot
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_have_ff <= 1'b0;
            awaddr_ff <= 32'h0;
        end else if (awvalid_in && awready_out) begin
            aw_have_ff <= 1'b1;
            awaddr_ff <= awaddr_in;
        end else if (wr_en_out) begin
            aw_have_ff <= 1'b0;
        end
    end

    // Write data slot
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            w_have_ff <= 1'b0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else if (wvalid_in && wready_out) begin
            w_have_ff <= 1'b1;
            wdata_ff <= wdata_in;
            wstrb_ff <= wstrb_in;
        end else if (wr_en_out) begin
            w_have_ff <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bvalid_out <= 1'b0;
            bresp_out <= SPP_RESP_OKAY;
        end else if (wr_en_out) begin
            bvalid_out <= 1'b1;
            bresp_out <= wr_hit_in ? SPP_RESP_OKAY : SPP_RESP_SLVERR;
        end else if (bready_in) begin
            bvalid_out <= 1'b0;
        end
    end

    // Read address capture
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_pend_ff <= 1'b0;
            araddr_ff <= 32'h0;
        end else if (arvalid_in && arready_out) begin
            rd_pend_ff <= 1'b1;
            araddr_ff <= araddr_in;
        end else begin
            rd_pend_ff <= 1'b0;
        end
    end

    // Read data channel
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0;
            rresp_out <= SPP_RESP_OKAY;
        end else if (rd_pend_ff) begin
            rvalid_out <= 1'b1;
            rdata_out <= rd_hit_in ? rd_data_in : 32'h0;
            rresp_out <= rd_hit_in ? SPP_RESP_OKAY : SPP_RESP_SLVERR;
        end else if (rready_in) begin
            rvalid_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- logic/spp_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module spp_top
    import spp_pkg::*;
#(
    parameter int unsigned WIDTH = SPP_WIDTH
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [31:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [31:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic [WIDTH-1:0] PIN_IN,
    output logic [WIDTH-1:0] PIN_OUT,
    output logic [WIDTH-1:0] PIN_OE_OUT,
    input wire logic [2:0] SERIAL_TRANSMIT_IN,
    input wire logic [1:0] SERIAL_CLOCK_DRIVE_IN,
    output logic [2:0] SERIAL_RECEIVE_OUT,
    output logic [1:0] SERIAL_CLOCK_SENSE_OUT
);
    // The pin mux is fixed to eight positions
    if (WIDTH != SPP_WIDTH) begin : g_width_check
        $error("spp_top serves only an eight-bit port");
    end

    logic [7:0] pin_meta_ff;
    logic [7:0] pin_sync_ff;
    logic [7:0] data_latch_ff;
    logic [7:0] direction_ff;
    logic [7:0] function_ff;
    logic [7:0] open_drain_ff;
    logic [7:0] pin_out_ff;
    logic [7:0] pin_oe_ff;
    logic [2:0] serial_receive_ff;
    logic [1:0] serial_clock_sense_ff;
    logic [7:0] fn_value;
    logic [7:0] nxt_pin_out;
    logic [7:0] nxt_pin_oe;
    logic [7:0] port_view;
    logic [7:0] read_byte;
    logic wr_en;
    spp_wr_t wr;
    logic rd_en;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    spp_sel_t wr_sel;
    spp_sel_t rd_sel;
    logic wr_lane0;

    // Bus slave
    spp_axil u_axil (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .awaddr_in(S_AXI_AWADDR_IN),
        .awvalid_in(S_AXI_AWVALID_IN),
        .awready_out(S_AXI_AWREADY_OUT),
        .wdata_in(S_AXI_WDATA_IN),
        .wstrb_in(S_AXI_WSTRB_IN),
        .wvalid_in(S_AXI_WVALID_IN),
        .wready_out(S_AXI_WREADY_OUT),
        .bresp_out(S_AXI_BRESP_OUT),
        .bvalid_out(S_AXI_BVALID_OUT),
        .bready_in(S_AXI_BREADY_IN),
        .araddr_in(S_AXI_ARADDR_IN),
        .arvalid_in(S_AXI_ARVALID_IN),
        .arready_out(S_AXI_ARREADY_OUT),
        .rdata_out(S_AXI_RDATA_OUT),
        .rresp_out(S_AXI_RRESP_OUT),
        .rvalid_out(S_AXI_RVALID_OUT),
        .rready_in(S_AXI_RREADY_IN),
        .wr_en_out(wr_en),
        .wr_out(wr),
        .wr_hit_in(wr_sel != SPP_SEL_NONE),
        .rd_en_out(rd_en),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data),
        .rd_hit_in(rd_sel != SPP_SEL_NONE)
    );

    // Register selects
    assign wr_sel = spp_decode(wr.addr);
    assign rd_sel = spp_decode(rd_addr);
    assign wr_lane0 = wr_en && wr.strb[0];

    // Pin synchroniser
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            pin_meta_ff <= 8'h00;
            pin_sync_ff <= 8'h00;
        end else begin
            pin_meta_ff <= PIN_IN;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Output latch, all ones after reset
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            data_latch_ff <= SPP_RST_DATA;
        end else if (wr_lane0 && wr_sel == SPP_SEL_DATA) begin
            data_latch_ff <= wr.data[7:0];
        end
    end

    // Direction register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            direction_ff <= SPP_RST_DIR;
        end else if (wr_lane0 && wr_sel == SPP_SEL_DIR) begin
            direction_ff <= wr.data[7:0];
        end
    end

    // Function select register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            function_ff <= SPP_RST_FUNC;
        end else if (wr_lane0 && wr_sel == SPP_SEL_FUNC) begin
            function_ff <= wr.data[7:0];
        end
    end

    // Open-drain select, only implemented bits hold
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            open_drain_ff <= SPP_RST_OD;
        end else if (wr_lane0 && wr_sel == SPP_SEL_OD) begin
            open_drain_ff <= wr.data[7:0] & SPP_OD_MASK;
        end
    end

    // Per-bit function source and pin drive
    for (genvar i = 0; i < 8; i++) begin : g_bit
        if (SPP_TX_BITS[i]) begin : g_tx
            assign fn_value[i] = SERIAL_TRANSMIT_IN[i / SPP_CH_STRIDE];
        end else if (SPP_CLK_BITS[i]) begin : g_clk
            assign fn_value[i] = SERIAL_CLOCK_DRIVE_IN[i / SPP_CH_STRIDE];
        end else begin : g_rx
            assign fn_value[i] = data_latch_ff[i];
        end
        // Port latch or serial signal
        assign nxt_pin_out[i] = function_ff[i] ? fn_value[i] : data_latch_ff[i];
        // Open drain releases the pin instead of driving high
        assign nxt_pin_oe[i] = direction_ff[i] && !(open_drain_ff[i] && nxt_pin_out[i]);
        // Data read view
        assign port_view[i] = direction_ff[i] ? data_latch_ff[i] : pin_sync_ff[i];
    end

    // Registered pin drive
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            pin_out_ff <= SPP_RST_DATA;
            pin_oe_ff <= 8'h00;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    // Receive lines to the serial channels, idle high when not routed
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            serial_receive_ff <= 3'h7;
        end else begin
            for (int k = 0; k < 3; k++) begin
                serial_receive_ff[k] <= function_ff[k * SPP_CH_STRIDE + 1]
                    ? pin_sync_ff[k * SPP_CH_STRIDE + 1] : 1'b1;
            end
        end
    end

    // Clock or clear-to-send input when the clock pin is an input
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            serial_clock_sense_ff <= 2'h3;
        end else begin
            for (int k = 0; k < 2; k++) begin
                serial_clock_sense_ff[k] <= (function_ff[k * SPP_CH_STRIDE + 2]
                    && !direction_ff[k * SPP_CH_STRIDE + 2])
                    ? pin_sync_ff[k * SPP_CH_STRIDE + 2] : 1'b1;
            end
        end
    end

    // Read mux
    always_comb begin
        read_byte = 8'h00;
        unique case (rd_sel)
            SPP_SEL_DATA: read_byte = port_view;
            SPP_SEL_DIR: read_byte = direction_ff;
            SPP_SEL_FUNC: read_byte = function_ff;
            SPP_SEL_OD: read_byte = open_drain_ff & SPP_OD_MASK;
            SPP_SEL_NONE: read_byte = 8'h00;
        endcase
    end
    assign rd_data = {24'h0, read_byte};

    // Outputs from flops
    assign PIN_OUT = pin_out_ff;
    assign PIN_OE_OUT = pin_oe_ff;
    assign SERIAL_RECEIVE_OUT = serial_receive_ff;
    assign SERIAL_CLOCK_SENSE_OUT = serial_clock_sense_ff;
endmodule
`default_nettype wire

//--- bench/spp_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module spp_monitor
    import spp_pkg::*;
#(
    parameter int unsigned WIDTH = SPP_WIDTH
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic S_AXI_AWVALID_IN,
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_WVALID_IN,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic [1:0] S_AXI_BRESP_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic [WIDTH-1:0] PIN_IN,
    input wire logic [WIDTH-1:0] PIN_OUT,
    input wire logic [WIDTH-1:0] PIN_OE_OUT,
    input wire logic [2:0] SERIAL_RECEIVE_OUT,
    input wire logic [1:0] SERIAL_CLOCK_SENSE_OUT
);
    // One domain, reset masks everything
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // Pin and serial state on leaving reset
    a_reset_pins: assert property ($fell(RST_IN) |->
        PIN_OUT == 8'hFF && PIN_OE_OUT == 8'h00) else $error("pins wrong after reset");
    a_reset_serial: assert property ($fell(RST_IN) |->
        SERIAL_RECEIVE_OUT == 3'h7 && SERIAL_CLOCK_SENSE_OUT == 2'h3) else $error("serial wrong after reset");
    // Low toward a channel only from a low pin
    a_recv_source: assert property ((~SERIAL_RECEIVE_OUT &
        {$past(PIN_IN[7], 3), $past(PIN_IN[4], 3), $past(PIN_IN[1], 3)}) == 3'h0) else $error("receive source");
    a_sense_source: assert property ((~SERIAL_CLOCK_SENSE_OUT &
        {$past(PIN_IN[5], 3), $past(PIN_IN[2], 3)}) == 2'h0) else $error("clock sense source");
    // Bus answers: timing, holding and zero upper read bits
    a_wr_answer: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN &&
        S_AXI_WREADY_OUT |-> ##2 S_AXI_BVALID_OUT) else $error("write answer late");
    a_rd_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |-> ##2 S_AXI_RVALID_OUT)
        else $error("read answer late");
    a_b_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
        S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write answer dropped");
    a_r_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
        S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read answer dropped");
    a_r_upper: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h0)
        else $error("read upper bits set");
endmodule
`default_nettype wire

//--- bench/spp_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module spp_pin_model
    import spp_pkg::*;
(
    input wire logic [7:0] pin_out_in,
    input wire logic [7:0] pin_oe_in,
    input wire logic [7:0] ext_level_in,
    input wire logic [2:0] tx_level_in,
    input wire logic [1:0] sck_level_in,
    output logic [7:0] pin_level_out,
    output logic [2:0] transmit_out,
    output logic [1:0] clock_out
);
    // Wire level: device where enabled, board drive elsewhere
    assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
    // Serial channel sources, same clock
    assign transmit_out = tx_level_in;
    assign clock_out = sck_level_in;
endmodule
`default_nettype wire

//--- bench/spp_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spp_top_tb;
    import spp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rrd = 1'b0;
    logic [3:0] ws = 4'h0;
    logic [7:0] ext = 8'hA5, pin, pout, poe;
    logic [2:0] tx = 3'h0, txw, recv;
    logic [1:0] sck = 2'h0, sckw, sense, bresp, rresp;
    logic awr, wr, bv, arr, rvl;
    logic [31:0] rdata;
    int failures = 0, cmp_count = 0, cyc = 0;

    spp_top uut (.CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
        .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
        .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvl), .S_AXI_RREADY_IN(rrd), .PIN_IN(pin),
        .PIN_OUT(pout), .PIN_OE_OUT(poe), .SERIAL_TRANSMIT_IN(txw), .SERIAL_CLOCK_DRIVE_IN(sckw),
        .SERIAL_RECEIVE_OUT(recv), .SERIAL_CLOCK_SENSE_OUT(sense));
    spp_pin_model pins (.pin_out_in(pout), .pin_oe_in(poe), .ext_level_in(ext), .tx_level_in(tx),
        .sck_level_in(sck), .pin_level_out(pin), .transmit_out(txw), .clock_out(sckw));

    // Clock and hang guard
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            results();
        end
    end

    task automatic results();
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Write: payload held until each ready, answer taken at bvalid
    task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ha, hw, hb;
        int n;
        hb = 1'b0;
        n = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        ws <= 4'hF;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!hb && n < 40) begin
            @(negedge clk);
            ha = awv && awr;
            hw = wv && wr;
            hb = bv;
            n++;
            if (hb) chk("bresp", er, bresp);
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
            if (hb) br <= 1'b0;
        end
        if (!hb) chk("bvalid", 32'h1, 32'h0);
    endtask

    // Read and compare data and response
    task automatic rdc(input string s, input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ha, hb;
        int n;
        hb = 1'b0;
        n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        while (!hb && n < 40) begin
            @(negedge clk);
            ha = arv && arr;
            hb = rvl;
            n++;
            if (hb) chk(s, e, rdata);
            if (hb) chk("rresp", er, rresp);
            @(posedge clk);
            if (ha) arv <= 1'b0;
            if (hb) rrd <= 1'b0;
        end
        if (!hb) chk("rvalid", 32'h1, 32'h0);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("pin_out", 8'hFF, pout);
        chk("pin_oe", 8'h00, poe);
        rdc("data", SPP_ADDR_DATA, {24'h0, ext}, SPP_RESP_OKAY);
        rdc("dir", SPP_ADDR_DIR, 32'h0, SPP_RESP_OKAY);
        rdc("func", SPP_ADDR_FUNC, 32'h0, SPP_RESP_OKAY);
        rdc("od", SPP_ADDR_OD, 32'h0, SPP_RESP_OKAY);
    endtask

    // Mixed direction, upper write bits ignored, unmapped access
    task automatic t_dir();
        wrc(SPP_ADDR_DIR, 32'h0F, SPP_RESP_OKAY);
        settle();
        chk("pin_out", 8'hFF, pout);
        chk("pin_oe", 8'h0F, poe);
        wrc(SPP_ADDR_DATA, 32'hFFFFFF3C, SPP_RESP_OKAY);
        settle();
        chk("pin_oe", 8'h0F, poe);
        chk("pin_out", 8'h3C, pout);
        rdc("data", SPP_ADDR_DATA, 32'hAC, SPP_RESP_OKAY);
        wrc(SPP_ADDR_OD + 32'h10, 32'hFF, SPP_RESP_SLVERR);
        rdc("unmapped", SPP_ADDR_OD + 32'h10, 32'h0, SPP_RESP_SLVERR);
        rdc("dir", SPP_ADDR_DIR, 32'h0F, SPP_RESP_OKAY);
    endtask

    // Open drain only on implemented bits, drives low only
    task automatic t_od();
        wrc(SPP_ADDR_OD, 32'hFF, SPP_RESP_OKAY);
        rdc("od", SPP_ADDR_OD, 32'h6D, SPP_RESP_OKAY);
        wrc(SPP_ADDR_DIR, 32'hFF, SPP_RESP_OKAY);
        wrc(SPP_ADDR_DATA, 32'hFF, SPP_RESP_OKAY);
        settle();
        chk("pin_oe", 8'h92, poe);
        wrc(SPP_ADDR_DATA, 32'h00, SPP_RESP_OKAY);
        settle();
        chk("pin_oe", 8'hFF, poe);
        wrc(SPP_ADDR_OD, 32'h00, SPP_RESP_OKAY);
    endtask

    // Serial routing out and in, then back to port
    task automatic t_func();
        wrc(SPP_ADDR_DIR, 32'h6D, SPP_RESP_OKAY);
        tx <= 3'b101;
        sck <= 2'b10;
        wrc(SPP_ADDR_FUNC, 32'hFF, SPP_RESP_OKAY);
        settle();
        chk("pin_out", 8'h61, pout);
        chk("receive", 3'b100, recv);
        chk("sense", 2'b11, sense);
        tx <= 3'b010;
        sck <= 2'b01;
        settle();
        chk("pin_out", 8'h0C, pout);
        rdc("func", SPP_ADDR_FUNC, 32'hFF, SPP_RESP_OKAY);
        wrc(SPP_ADDR_FUNC, 32'h00, SPP_RESP_OKAY);
        ext <= 8'h5A;
        wrc(SPP_ADDR_DIR, 32'h00, SPP_RESP_OKAY);
        wrc(SPP_ADDR_FUNC, 32'hFF, SPP_RESP_OKAY);
        settle();
        chk("receive", 3'b011, recv);
        chk("sense", 2'b00, sense);
        rdc("data", SPP_ADDR_DATA, 32'h5A, SPP_RESP_OKAY);
        wrc(SPP_ADDR_FUNC, 32'h00, SPP_RESP_OKAY);
        settle();
        chk("receive", 3'b111, recv);
        chk("sense", 2'b11, sense);
    endtask

    // Main sequence, second reset after traffic
    initial begin
        t_reset();
        t_dir();
        t_od();
        t_func();
        t_reset();
        results();
    end
endmodule

bind spp_top spp_monitor #(.WIDTH(WIDTH)) mon (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
    .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN), .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
    .S_AXI_WVALID_IN(S_AXI_WVALID_IN), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
    .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
    .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
    .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT),
    .SERIAL_RECEIVE_OUT(SERIAL_RECEIVE_OUT), .SERIAL_CLOCK_SENSE_OUT(SERIAL_CLOCK_SENSE_OUT));
`default_nettype wire
